// File: design/sms_pkg.sv
// sms_pkg: shared constants and types of the spi master/slave shift engine.
// assumes a single 100 MHz system clock; no bus, all controls are plain ports.
`default_nettype none

package sms_pkg;

    // ****************************************************************
    // sizes and counts
    // ****************************************************************
    localparam int          SMS_DATA_W     = 8;
    localparam int          SMS_FIFO_DEPTH = 8;
    localparam int          SMS_RATE_W     = 3;
    // widest half period: (7+1) << 7 system clocks
    localparam int          SMS_HALF_W     = 11;
    localparam int          SMS_CFG_W      = 13;
    localparam logic [3:0]  SMS_SYS_CLK_NS = 4'ha;

    // ****************************************************************
    // values after reset
    // ****************************************************************
    localparam logic        SMS_RST_MASTER = 1'b0;
    localparam logic        SMS_RST_FLAG   = 1'b0;
    localparam logic        SMS_RST_TEF    = 1'b1;
    localparam logic        SMS_RST_SS_N   = 1'b1;
    localparam logic        SMS_RST_PREV   = 1'b1;

    // ****************************************************************
    // engine states
    // ****************************************************************
    typedef enum logic [3:0] {
        SMS_IDLE  = 4'h1,
        SMS_LEAD  = 4'h2,
        SMS_RUN   = 4'h4,
        SMS_TRAIL = 4'h8
    } sms_state_t;

endpackage : sms_pkg

`default_nettype wire

// File: design/sms_fifo.sv
// sms_fifo: transmit byte queue between the data register and the shifter.
// assumes the drain side may hold out_ready low for any time.
`default_nettype none

module sms_fifo #(
    parameter int WIDTH = 8,
    parameter int DEPTH = 8
) (
    // clock and reset
    input  wire logic             sys_clk,
    input  wire logic             reset_n,
    // fill side
    input  wire logic             in_valid,
    output logic                  in_ready,
    input  wire logic [WIDTH-1:0] in_data,
    // drain side
    output logic                  out_valid,
    input  wire logic             out_ready,
    output logic [WIDTH-1:0]      out_data
);

    localparam int AW = (DEPTH > 1) ? $clog2(DEPTH) : 1;
    localparam int CW = $clog2(DEPTH + 1);

    logic [WIDTH-1:0] mem [DEPTH];
    logic [AW-1:0]    wr_ptr_ff;
    logic [AW-1:0]    rd_ptr_ff;
    logic [CW-1:0]    count_ff;
    wire              push;
    wire              pop;

    assign in_ready  = (count_ff != CW'(DEPTH));
    assign out_valid = (count_ff != '0);
    assign out_data  = mem[rd_ptr_ff];
    assign push      = in_valid & in_ready;
    assign pop       = out_valid & out_ready;

    function automatic logic [AW-1:0] ptr_inc(input logic [AW-1:0] p);
        return (p == AW'(DEPTH - 1)) ? '0 : AW'(p + 1'b1);
    endfunction

    always_ff @(posedge sys_clk) begin
        if (push) begin
            mem[wr_ptr_ff] <= in_data;
        end
    end

    always_ff @(posedge sys_clk or negedge reset_n) begin
        if (!reset_n) begin
            wr_ptr_ff <= '0;
            rd_ptr_ff <= '0;
            count_ff  <= '0;
        end else begin
            if (push) wr_ptr_ff <= ptr_inc(wr_ptr_ff);
            if (pop)  rd_ptr_ff <= ptr_inc(rd_ptr_ff);
            if (push && !pop) count_ff <= CW'(count_ff + 1'b1);
            else if (pop && !push) count_ff <= CW'(count_ff - 1'b1);
        end
    end

endmodule // sms_fifo

`default_nettype wire

// File: design/sms_shifter.sv
// sms_shifter: byte-wide spi shift engine, master or slave, with mode fault.
// assumes all inputs (pins included) are synchronous to sys_clk and that
// outside logic resolves each pin from its output enable.
//
// Contract
// - master with fault detect and select output drives select low only while busy
// - master fault-detect input seeing select low drops to slave, outputs off
// - mode fault during a transfer abandons it and returns the engine to idle
// - mode fault sets fault flag; interrupt request raised when enabled
// - master waits a full sck period (leading half plus one half) after data write before first edge
// - master config or rate change aborts the transfer and forces idle
// - slave returns to idle whenever select input goes high
// - unselected slave tristates data out, ignores sck, never shifts
// - slave phase 0 presents first bit at select low, phase 1 at edge one
// - phase 0 samples on odd edges, shifts on even edges per bit order
// - phase 1 samples on even edges, shifts on odd edges after edge one and on edge sixteen, per bit order
// - after eight shifts copy byte to receive register unless one is unread, set done flag
// - sixteen edges half a period apart; first edge a full period after select
// - slave kept selected, deselected under a half period or with an empty queue sends back the received byte, else sends queued data
// - master keeps leading, trailing and idle times; slave expects them
// - polarity only inverts sck idle level; phase picks the format
// - sck divisor is (preselect+1) times two to the (select+1)
// - single wire uses master mosi or slave miso, direction by enable
// - data writes ignored unless status read with transmit empty first
// - fault flag cleared by status read then control register one write
`default_nettype none

module sms_shifter #(
    parameter int DATA_W     = sms_pkg::SMS_DATA_W,
    parameter int FIFO_DEPTH = sms_pkg::SMS_FIFO_DEPTH
) (
    // clock and reset
    input  wire logic                          sys_clk,
    input  wire logic                          reset_n,
    // control register one
    input  wire logic                          ctrl_one_wr,
    input  wire logic                          master_select_wr,
    input  wire logic                          clock_polarity,
    input  wire logic                          clock_phase,
    input  wire logic                          select_output_enable,
    input  wire logic                          lsb_first_enable,
    input  wire logic                          interrupt_enable_bit,
    // control register two and rate
    input  wire logic                          fault_detect_enable,
    input  wire logic                          single_wire_select,
    input  wire logic                          single_wire_output_enable,
    input  wire logic [sms_pkg::SMS_RATE_W-1:0] rate_preselect_bits,
    input  wire logic [sms_pkg::SMS_RATE_W-1:0] rate_select_bits,
    // status
    input  wire logic                          status_rd,
    output logic                               master_select,
    output logic                               transfer_done_flag,
    output logic                               transmit_empty_flag,
    output logic                               fault_flag,
    output logic                               irq,
    // data register
    input  wire logic                          data_wr,
    input  wire logic [DATA_W-1:0]             data_wr_byte,
    input  wire logic                          data_rd,
    output logic [DATA_W-1:0]                  rx_byte,
    // spi pins
    input  wire logic                          sck_in,
    output logic                               sck_out,
    output logic                               sck_oe,
    input  wire logic                          mosi_in,
    output logic                               mosi_out,
    output logic                               mosi_oe,
    input  wire logic                          miso_in,
    output logic                               miso_out,
    output logic                               miso_oe,
    input  wire logic                          ss_in_n,
    output logic                               ss_out_n,
    output logic                               ss_oe
);

    localparam int               HW        = sms_pkg::SMS_HALF_W;
    localparam int               EW        = $clog2(2 * DATA_W + 1);
    localparam logic [EW-1:0]    LAST_EDGE = EW'(2 * DATA_W);
    localparam logic [EW-1:0]    FIRST_EDGE = EW'(1);

    // ****************************************************************
    // helpers
    // ****************************************************************
    // half sck period in system clocks: the full divisor over two
    function automatic logic [HW-1:0] half_count(input logic [2:0] pre,
                                                 input logic [2:0] sel);
        logic [HW-1:0] p;
        p = HW'(pre) + HW'(1);
        return HW'(p << sel);
    endfunction

    function automatic logic [DATA_W-1:0] shift_in(input logic [DATA_W-1:0] r,
                                                   input logic b,
                                                   input logic lsbf);
        return lsbf ? {b, r[DATA_W-1:1]} : {r[DATA_W-2:0], b};
    endfunction

    // ****************************************************************
    // state
    // ****************************************************************
    sms_pkg::sms_state_t             state_ff;
    sms_pkg::sms_state_t             nxt_state;
    logic                            master_ff;
    logic [HW-1:0]                   half_cnt_ff;
    logic [HW-1:0]                   ss_hi_cnt_ff;
    logic [EW-1:0]                   edge_cnt_ff;
    logic                            sck_lvl_ff;
    logic                            sck_prev_ff;
    logic                            ss_prev_ff;
    logic [DATA_W-1:0]               shreg_ff;
    logic [DATA_W-1:0]               nxt_shreg;
    logic                            latch_ff;
    logic [DATA_W-1:0]               rx_ff;
    logic                            done_ff;
    logic                            done_arm_ff;
    logic                            fault_ff;
    logic                            fault_arm_ff;
    logic                            tef_ff;
    logic                            tef_arm_ff;
    logic                            irq_ff;
    logic [sms_pkg::SMS_CFG_W-1:0]   cfg_q_ff;
    logic                            data_ff;
    logic                            sck_out_ff;
    logic                            sck_oe_ff;
    logic                            mosi_oe_ff;
    logic                            miso_oe_ff;
    logic                            ss_out_n_ff;
    logic                            ss_oe_ff;

    // ****************************************************************
    // decode
    // ****************************************************************
    wire [HW-1:0] half_len = half_count(rate_preselect_bits, rate_select_bits);
    wire          tick     = (half_cnt_ff >= HW'(half_len - HW'(1)));
    wire          busy_m   = master_ff & (state_ff != sms_pkg::SMS_IDLE);

    wire          mode_fault = master_ff & fault_detect_enable
                             & ~select_output_enable & ~ss_in_n;
    wire [sms_pkg::SMS_CFG_W-1:0] cfg_vec = {clock_polarity, clock_phase,
                             select_output_enable, lsb_first_enable, fault_detect_enable,
                             single_wire_select, single_wire_select & single_wire_output_enable,
                             rate_preselect_bits, rate_select_bits};
    wire          cfg_change = master_ff & (cfg_vec != cfg_q_ff);
    wire          role_chg   = ctrl_one_wr & (master_select_wr != master_ff);
    wire          abort      = mode_fault | cfg_change | role_chg;

    // single wire: master uses mosi pin, slave uses miso pin
    wire          data_in = master_ff ? (single_wire_select ? mosi_in : miso_in)
                                      : (single_wire_select ? miso_in : mosi_in);

    wire          slave_sel = ~master_ff & ~ss_in_n;
    wire          m_edge    = master_ff & (state_ff == sms_pkg::SMS_RUN) & tick;
    // unselected slave never sees sck
    wire          s_edge    = slave_sel & (state_ff == sms_pkg::SMS_RUN)
                            & (sck_in != sck_prev_ff);
    wire          edge_ev   = (m_edge | s_edge) & ~abort;
    wire [EW-1:0] edge_num  = EW'(edge_cnt_ff + FIRST_EDGE);
    wire          odd_edge  = edge_num[0];
    wire          samp_edge = edge_ev & (odd_edge ^ clock_phase);
    wire          last_edge = edge_ev & (edge_num == LAST_EDGE);
    // phase 1 edge one only launches the first bit, no shift
    wire          shift_edge = edge_ev & ~(odd_edge ^ clock_phase)
                             & (edge_num != FIRST_EDGE);
    // phase 1 edge sixteen samples and takes the final shift in one go
    wire          fin_shift = clock_phase & last_edge;
    wire          do_shift  = shift_edge | fin_shift;
    wire          shift_bit = fin_shift ? data_in : latch_ff;
    wire [DATA_W-1:0] shifted = shift_in(shreg_ff, shift_bit, lsb_first_enable);

    wire          fifo_in_ready;
    wire          fifo_out_valid;
    wire [DATA_W-1:0] fifo_out_data;
    wire          wr_ok   = data_wr & tef_arm_ff;
    wire          m_load  = master_ff & (state_ff == sms_pkg::SMS_IDLE)
                          & fifo_out_valid & ~abort;
    wire          ss_fall = ss_prev_ff & ~ss_in_n;
    wire          hi_long = (ss_hi_cnt_ff >= half_len);
    // short deselect keeps the received byte in the shifter for resend
    wire          s_load  = ~master_ff & ss_fall & hi_long & fifo_out_valid;
    wire          fifo_pop = m_load | s_load;

    wire          m_done  = master_ff & (state_ff == sms_pkg::SMS_TRAIL) & tick & ~abort;
    wire          s_done  = ~master_ff & last_edge;
    wire          done_ev = m_done | s_done;
    wire [DATA_W-1:0] cap_byte = master_ff ? shreg_ff : shifted;

    wire          bit_out = lsb_first_enable ? shreg_ff[0] : shreg_ff[DATA_W-1];
    // phase 1 holds the line until the first edge launches bit one
    wire          present = ~clock_phase | (edge_cnt_ff != '0);

    // ****************************************************************
    // transmit queue
    // ****************************************************************
    sms_fifo #(
        .WIDTH (DATA_W),
        .DEPTH (FIFO_DEPTH)
    ) u_tx_fifo (
        .sys_clk   (sys_clk),
        .reset_n   (reset_n),
        .in_valid  (wr_ok),
        .in_ready  (fifo_in_ready),
        .in_data   (data_wr_byte),
        .out_valid (fifo_out_valid),
        .out_ready (fifo_pop),
        .out_data  (fifo_out_data)
    );

    // ****************************************************************
    // engine sequence
    // ****************************************************************
    always_comb begin
        nxt_state = state_ff;
        case (state_ff)
            sms_pkg::SMS_IDLE: begin
                if (m_load) nxt_state = sms_pkg::SMS_LEAD;
                else if (slave_sel && !abort) nxt_state = sms_pkg::SMS_RUN;
            end
            sms_pkg::SMS_LEAD: begin
                if (abort || !master_ff) nxt_state = sms_pkg::SMS_IDLE;
                else if (tick) nxt_state = sms_pkg::SMS_RUN;
            end
            sms_pkg::SMS_RUN: begin
                if (abort) nxt_state = sms_pkg::SMS_IDLE;
                else if (!master_ff && ss_in_n) nxt_state = sms_pkg::SMS_IDLE;
                else if (master_ff && last_edge) nxt_state = sms_pkg::SMS_TRAIL;
            end
            sms_pkg::SMS_TRAIL: begin
                // trailing half period before done, then at least one idle clock
                if (abort || tick || !master_ff) nxt_state = sms_pkg::SMS_IDLE;
            end
            default: nxt_state = sms_pkg::SMS_IDLE;
        endcase
    end

    always_comb begin
        nxt_shreg = shreg_ff;
        if (fifo_pop) nxt_shreg = fifo_out_data;
        else if (do_shift) nxt_shreg = shifted;
    end

    always_ff @(posedge sys_clk or negedge reset_n) begin
        if (!reset_n) begin
            state_ff    <= sms_pkg::SMS_IDLE;
            half_cnt_ff <= '0;
            edge_cnt_ff <= '0;
            sck_lvl_ff  <= 1'b0;
            shreg_ff    <= '0;
            latch_ff    <= 1'b0;
        end else begin
            state_ff    <= nxt_state;
            half_cnt_ff <= (nxt_state != state_ff || tick || !busy_m) ? '0
                         : HW'(half_cnt_ff + HW'(1));
            edge_cnt_ff <= (state_ff != sms_pkg::SMS_RUN || last_edge || abort) ? '0
                         : (edge_ev ? edge_num : edge_cnt_ff);
            // polarity is applied only at the pin
            sck_lvl_ff  <= (nxt_state == sms_pkg::SMS_IDLE) ? 1'b0
                         : (m_edge ? ~sck_lvl_ff : sck_lvl_ff);
            shreg_ff    <= nxt_shreg;
            latch_ff    <= samp_edge ? data_in : latch_ff;
        end
    end

    // ****************************************************************
    // role, flags and received byte
    // ****************************************************************
    always_ff @(posedge sys_clk or negedge reset_n) begin
        if (!reset_n) begin
            master_ff    <= sms_pkg::SMS_RST_MASTER;
            cfg_q_ff     <= '0;
            rx_ff        <= '0;
            done_ff      <= sms_pkg::SMS_RST_FLAG;
            done_arm_ff  <= 1'b0;
            fault_ff     <= sms_pkg::SMS_RST_FLAG;
            fault_arm_ff <= 1'b0;
            tef_ff       <= sms_pkg::SMS_RST_TEF;
            tef_arm_ff   <= 1'b0;
            irq_ff       <= 1'b0;
            sck_prev_ff  <= 1'b0;
            ss_prev_ff   <= sms_pkg::SMS_RST_PREV;
            ss_hi_cnt_ff <= '0;
        end else begin
            // a fault beats a software write to the master bit
            master_ff    <= mode_fault ? 1'b0
                          : (ctrl_one_wr ? master_select_wr : master_ff);
            cfg_q_ff     <= cfg_vec;
            // unread byte is kept, later bytes are lost
            rx_ff        <= (done_ev && !done_ff) ? cap_byte : rx_ff;
            done_ff      <= done_ev | (done_ff & ~(done_arm_ff & data_rd));
            done_arm_ff  <= data_rd ? 1'b0 : (done_arm_ff | (status_rd & done_ff));
            fault_ff     <= mode_fault
                          | (fault_ff & ~(fault_arm_ff & ctrl_one_wr));
            fault_arm_ff <= ctrl_one_wr ? 1'b0 : (fault_arm_ff | (status_rd & fault_ff));
            tef_ff       <= fifo_in_ready;
            tef_arm_ff   <= data_wr ? 1'b0 : (tef_arm_ff | (status_rd & tef_ff));
            irq_ff       <= interrupt_enable_bit & (fault_ff | done_ff);
            sck_prev_ff  <= sck_in;
            ss_prev_ff   <= ss_in_n;
            ss_hi_cnt_ff <= !ss_in_n ? '0
                          : ((ss_hi_cnt_ff == '1) ? ss_hi_cnt_ff : HW'(ss_hi_cnt_ff + HW'(1)));
        end
    end

    // ****************************************************************
    // pin drivers
    // ****************************************************************
    always_ff @(posedge sys_clk or negedge reset_n) begin
        if (!reset_n) begin
            data_ff     <= 1'b0;
            sck_out_ff  <= 1'b0;
            sck_oe_ff   <= 1'b0;
            mosi_oe_ff  <= 1'b0;
            miso_oe_ff  <= 1'b0;
            ss_out_n_ff <= sms_pkg::SMS_RST_SS_N;
            ss_oe_ff    <= 1'b0;
        end else begin
            data_ff     <= present ? bit_out : data_ff;
            sck_out_ff  <= clock_polarity ^ sck_lvl_ff;
            sck_oe_ff   <= master_ff & ~mode_fault;
            mosi_oe_ff  <= master_ff & ~mode_fault
                         & (~single_wire_select | single_wire_output_enable);
            // a standing fault keeps the demoted engine off the data pin
            miso_oe_ff  <= slave_sel & ~fault_ff
                         & (~single_wire_select | single_wire_output_enable);
            ss_out_n_ff <= ~busy_m;
            ss_oe_ff    <= master_ff & fault_detect_enable & select_output_enable;
        end
    end

    assign master_select       = master_ff;
    assign transfer_done_flag  = done_ff;
    assign transmit_empty_flag = tef_ff;
    assign fault_flag          = fault_ff;
    assign irq                 = irq_ff;
    assign rx_byte             = rx_ff;
    assign sck_out             = sck_out_ff;
    assign sck_oe              = sck_oe_ff;
    assign mosi_out            = data_ff;
    assign mosi_oe             = mosi_oe_ff;
    assign miso_out            = data_ff;
    assign miso_oe             = miso_oe_ff;
    assign ss_out_n            = ss_out_n_ff;
    assign ss_oe               = ss_oe_ff;

endmodule // sms_shifter

`default_nettype wire

// File: testbench/sms_shifter_props.sv
// checker: port-level timing of the spi shift engine
// assumes it is bound onto sms_shifter and shares its clock and reset
`default_nettype none
module sms_shifter_props (
    // clock, reset and controls
    input wire logic sys_clk,
    input wire logic reset_n,
    input wire logic interrupt_enable_bit,
    input wire logic clock_polarity,
    input wire logic ss_in_n,
    // watched outputs
    input wire logic master_select,
    input wire logic transfer_done_flag,
    input wire logic fault_flag,
    input wire logic irq,
    input wire logic sck_out,
    input wire logic sck_oe,
    input wire logic miso_oe,
    input wire logic ss_out_n,
    input wire logic ss_oe
);
    default clocking @(posedge sys_clk);
    endclocking
    default disable iff (!reset_n);
    // sck pin edges since select fell
    logic [4:0] edges_ff;
    always_ff @(posedge sys_clk or negedge reset_n)
        if (!reset_n) edges_ff <= 5'h0;
        else if ($fell(ss_out_n)) edges_ff <= 5'h0;
        else if (sck_oe && $changed(sck_out)) edges_ff <= edges_ff + 5'h1;
    sequence s_frame_start;
        ss_oe && $fell(ss_out_n);
    endsequence
    a_first_pol: assert property (s_frame_start |-> sck_out == clock_polarity)
        else $error("sck off idle level at frame start");
    a_edge_count: assert property ($rose(transfer_done_flag) && master_select
        && ss_oe |-> edges_ff == 5'h10) else $error("frame edge count wrong");
    a_done_idle: assert property ($rose(transfer_done_flag) && master_select
        |-> sck_out == clock_polarity) else $error("sck off idle level at done");
    a_fault_master: assert property ($rose(fault_flag) |-> !master_select)
        else $error("master bit kept after fault");
    a_fault_outs: assert property ($rose(fault_flag) |-> ##[0:2] !sck_oe)
        else $error("sck driven after fault");
    a_irq_fault: assert property (fault_flag && interrupt_enable_bit |=> irq)
        else $error("no interrupt for fault");
    a_irq_done: assert property (transfer_done_flag && interrupt_enable_bit |=> irq)
        else $error("no interrupt for done");
    a_unsel_tris: assert property ((!master_select && ss_in_n) [*3] |-> !miso_oe)
        else $error("unselected slave drives data");
endmodule // sms_shifter_props
`default_nettype wire

// File: testbench/sms_spi_slave.sv
// partner: external spi slave answering the engine in master mode
// assumes select is pulled up while the engine does not drive it
`default_nettype none
module sms_spi_slave (
    // spi wires
    input  wire logic       sck,
    input  wire logic       mosi,
    input  wire logic       ss_n,
    output logic            miso,
    // format and data
    input  wire logic       cpha,
    input  wire logic       lsbf,
    input  wire logic [7:0] tx,
    output logic      [7:0] rx
);
    timeunit 1ns;
    timeprecision 1ns;
    int   n;
    int   i;
    logic l;
    function automatic logic bit_at(int k);
        return lsbf ? tx[k] : tx[7-k];
    endfunction
    initial rx = 8'h00;
    // released line shows no stale bit
    always @(posedge ss_n) miso = ~miso;
    always @(negedge ss_n) begin
        n = 0;
        i = 0;
        if (!cpha) miso = bit_at(0);
    end
    always @(sck) if (!ss_n) begin
        n = n + 1;
        if (n % 2 == (cpha ? 0 : 1)) l = mosi;
        else begin
            if (!cpha || n > 1) rx = lsbf ? {l, rx[7:1]} : {rx[6:0], l};
            if (!cpha || n > 1) i = i + 1;
            if (i < 8) miso = bit_at(i);
        end
        if (cpha && n == 16) rx = lsbf ? {l, rx[7:1]} : {rx[6:0], l};
    end
endmodule // sms_spi_slave
`default_nettype wire

// File: testbench/sms_shifter_tb.sv
// bench: master frames against a slave model, mode fault, unarmed write
// assumes the engine, its checker and the slave model compile first
`default_nettype none
module sms_shifter_tb;
    timeunit 1ns;
    timeprecision 1ns;
    logic sys_clk = 1'b0, reset_n = 1'b0, ctrl_one_wr, master_select_wr, clock_polarity;
    logic clock_phase, select_output_enable, lsb_first_enable, interrupt_enable_bit;
    logic fault_detect_enable, single_wire_select, single_wire_output_enable, status_rd;
    logic data_wr, data_rd, ss_drv, slv_miso, master_select, transfer_done_flag;
    logic transmit_empty_flag, fault_flag, irq, sck_out, sck_oe, mosi_out, mosi_oe;
    logic miso_out, miso_oe, ss_out_n, ss_oe;
    logic [2:0] rate_preselect_bits, rate_select_bits;
    logic [7:0] data_wr_byte, slv_tx, slv_rx, rx_byte;
    wire logic sck_in = sck_oe ? sck_out : clock_polarity;
    wire logic mosi_in = mosi_oe ? mosi_out : 1'b1;
    wire logic miso_in = miso_oe ? miso_out : slv_miso;
    wire logic ss_in_n = ss_oe ? ss_out_n : ss_drv;
    int miscompares = 0, tests_run = 0, w;
    sms_shifter dut (.*);
    sms_spi_slave u_slv (.sck(sck_in), .mosi(mosi_in), .ss_n(ss_in_n), .miso(slv_miso),
        .cpha(clock_phase), .lsbf(lsb_first_enable), .tx(slv_tx), .rx(slv_rx));
    always #5 sys_clk = ~sys_clk;
    task automatic tick(int n = 1);
        repeat (n) @(posedge sys_clk);
    endtask
    task automatic chk(string nm, logic [7:0] e, logic [7:0] s);
        tests_run++;
        if (s !== e) begin
            miscompares++;
            $display("BAD %s exp %h got %h", nm, e, s);
        end
    endtask
    // status read, then data write (0), data read (1) or control write (2)
    task automatic armed(int op);
        status_rd <= 1'b1;
        tick();
        status_rd <= 1'b0;
        data_wr <= op == 0;
        data_rd <= op == 1;
        ctrl_one_wr <= op == 2;
        tick();
        {data_wr, data_rd, ctrl_one_wr} <= 3'h0;
    endtask
    task automatic wait_done();
        for (w = 0; w < 2000 && transfer_done_flag !== 1'b1; w++) tick();
        tick();
    endtask
    task automatic close_out();
        $display("compares %0d miscompares %0d", tests_run, miscompares);
        if (miscompares == 0 && tests_run > 0) $display("[ PASS ]");
        else $display("[ FAIL ]");
        $finish;
    endtask
    initial begin
        #200us;
        miscompares++;
        close_out();
    end
    initial begin
        {ctrl_one_wr, clock_polarity, clock_phase, lsb_first_enable, status_rd} = '0;
        {single_wire_select, single_wire_output_enable, data_wr, data_rd} = '0;
        {rate_preselect_bits, rate_select_bits, data_wr_byte, slv_tx} = '0;
        {master_select_wr, select_output_enable, interrupt_enable_bit} = '1;
        {fault_detect_enable, ss_drv} = '1;
        void'($urandom(32'ha404584e));
        tick(3);
        reset_n <= 1'b1;
        armed(2);
        // every phase and bit order, random polarity and rate
        for (int k = 0; k < 8; k++) begin
            clock_phase <= k[0];
            lsb_first_enable <= k[1];
            clock_polarity <= 1'($urandom);
            rate_select_bits <= 3'(1 + $urandom % 2);
            rate_preselect_bits <= 3'($urandom % 4);
            slv_tx <= k == 6 ? 8'h80 : 8'($urandom);
            data_wr_byte <= k == 7 ? 8'h01 : 8'($urandom);
            tick(2);
            armed(0);
            wait_done();
            chk("rx_byte", slv_tx, rx_byte);
            chk("slave rx", data_wr_byte, slv_rx);
            armed(1);
            $display("test %0d done", k);
        end
        // two writes on one arm: the second must not start a frame
        data_wr <= 1'b1;
        tick(2);
        data_wr <= 1'b0;
        wait_done();
        armed(1);
        tick(40);
        chk("second write", 1'b1, ss_out_n);
        chk("tef", 1'b1, transmit_empty_flag);
        $display("test unarmed done");
        select_output_enable <= 1'b0;
        tick(2);
        ss_drv <= 1'b0;
        tick(4);
        chk("fault_flag", 1'b1, fault_flag);
        chk("master_select", 1'b0, master_select);
        chk("irq", 1'b1, irq);
        chk("miso_oe", 1'b0, miso_oe);
        ss_drv <= 1'b1;
        armed(2);
        tick(2);
        chk("fault clear", 1'b0, fault_flag);
        $display("test fault done");
        close_out();
    end
endmodule // sms_shifter_tb
bind sms_shifter sms_shifter_props u_props (.sys_clk, .reset_n, .interrupt_enable_bit,
    .clock_polarity, .ss_in_n, .master_select, .transfer_done_flag, .fault_flag, .irq,
    .sck_out, .sck_oe, .miso_oe, .ss_out_n, .ss_oe);
`default_nettype wire
